/* File: include/timer16_defs.vh */
// Register offsets, field positions, reset values and timing counts for the 16-bit timer core
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH

// Register offsets (I/O address space, 8-bit)
`define T16_OFS_CTRL_A      8'h80
`define T16_OFS_CTRL_B      8'h81
`define T16_OFS_CTRL_C      8'h82
`define T16_OFS_CNT_LO      8'h84
`define T16_OFS_CNT_HI      8'h85
`define T16_OFS_CMPA_LO     8'h88
`define T16_OFS_CMPA_HI     8'h89
`define T16_OFS_CMPB_LO     8'h8a
`define T16_OFS_CMPB_HI     8'h8b
`define T16_OFS_CAP_LO      8'h86
`define T16_OFS_CAP_HI      8'h87
`define T16_OFS_FLAGS       8'h36

// Field positions
`define T16_A_COMA_HI       7
`define T16_A_COMA_LO       6
`define T16_A_COMB_HI       5
`define T16_A_COMB_LO       4
`define T16_A_WGM_HI        1
`define T16_A_WGM_LO        0
`define T16_B_NOISE         7
`define T16_B_EDGE          6
`define T16_B_RSVD          5
`define T16_B_WGM_HI        4
`define T16_B_WGM_LO        3
`define T16_B_CS_HI         2
`define T16_B_CS_LO         0
`define T16_C_FORCE_A       7
`define T16_C_FORCE_B       6
`define T16_F_CAP           5
`define T16_F_CMPB          2
`define T16_F_CMPA          1
`define T16_F_OVF           0

// Reset values and write masks
`define T16_CTRL_A_RST      8'h00
`define T16_CTRL_B_RST      8'h00
`define T16_CTRL_A_MASK     8'hf3
`define T16_CTRL_B_MASK     8'hdf

// Fixed TOP and BOTTOM values
`define T16_TOP_MAX         16'hffff
`define T16_TOP_8BIT        16'h00ff
`define T16_TOP_9BIT        16'h01ff
`define T16_TOP_10BIT       16'h03ff
`define T16_BOTTOM          16'h0000

// Update / overflow point codes
`define T16_PT_IMM          2'h0
`define T16_PT_TOP          2'h1
`define T16_PT_BOT          2'h2
`define T16_PT_MAX          2'h3

// Noise filter sample count and prescaler taps
`define T16_FILT_SAMPLES    4
`define T16_DIV_8           10'h007
`define T16_DIV_64          10'h03f
`define T16_DIV_256         10'h0ff
`define T16_DIV_1024        10'h3ff

`endif

/* File: core/timer16_prescaler.v */
// Clock source selection: prescaler taps and external count pin edge detection
`timescale 1ns/1ps
`include "timer16_defs.vh"

module timer16_prescaler (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Control
    input  wire [2:0] clock_source_sel,
    input  wire       ext_count_sync,
    // Timer tick
    output reg        tick_q
);
    reg  [9:0] div_q;
    reg        ext_prev_q;
    reg        tick_d;

    // Free-running prescaler counter
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q      <= 10'h000;
            ext_prev_q <= 1'b0;
            tick_q     <= 1'b0;
        end else begin
            div_q      <= div_q + 10'h001;
            ext_prev_q <= ext_count_sync;
            tick_q     <= tick_d;
        end
    end

    // Tick pulse from the selected source
    always @* begin
        case (clock_source_sel)
            3'h0: tick_d = 1'b0;
            3'h1: tick_d = 1'b1;
            3'h2: tick_d = ((div_q & `T16_DIV_8) == `T16_DIV_8);
            3'h3: tick_d = ((div_q & `T16_DIV_64) == `T16_DIV_64);
            3'h4: tick_d = ((div_q & `T16_DIV_256) == `T16_DIV_256);
            3'h5: tick_d = (div_q == `T16_DIV_1024);
            3'h6: tick_d = ext_prev_q & ~ext_count_sync;
            3'h7: tick_d = ~ext_prev_q & ext_count_sync;
            default: tick_d = 1'b0;
        endcase
    end
endmodule // timer16_prescaler

/* File: core/timer16_capture_filter.v */
// Input capture noise filter and edge detector
`timescale 1ns/1ps
`include "timer16_defs.vh"

module timer16_capture_filter (
    // Clock and reset
    input  wire clk,
    input  wire rst_n,
    // Control
    input  wire capture_noise_filter_en,
    input  wire capture_edge_sel,
    input  wire capture_enable,
    // Synchronised pin and event
    input  wire capture_sync,
    output reg  capture_event_q
);
    reg  [3:0] hist_q;
    reg        filt_q;
    reg        level_prev_q;
    wire       level;
    wire       all_hi;
    wire       all_lo;

    assign all_hi = &hist_q;
    assign all_lo = ~|hist_q;
    assign level  = capture_noise_filter_en ? filt_q : capture_sync;

    // Sample history, filtered level and edge event
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_q          <= 4'h0;
            filt_q          <= 1'b0;
            level_prev_q    <= 1'b0;
            capture_event_q <= 1'b0;
        end else begin
            hist_q <= {hist_q[2:0], capture_sync};
            if (all_hi) begin
                filt_q <= 1'b1;
            end else if (all_lo) begin
                filt_q <= 1'b0;
            end
            level_prev_q    <= level;
            capture_event_q <= capture_enable & (capture_edge_sel ?
                               (level & ~level_prev_q) :
                               (~level & level_prev_q));
        end
    end
endmodule // timer16_capture_filter

/* File: core/timer16_core.v */
// 16-bit timer/counter control core: mode decode, clocking, capture, force and CPU access
// Functional notes
// - Mode is two low bits of control A plus two bits of control B.
// - Modes 0, 4, 12: TOP max/compare A/capture, immediate update, flag at MAX.
// - Phase-correct 1,2,3,10,11: update at TOP, overflow flag at BOTTOM.
// - Fast PWM 5,6,7,14,15: update at BOTTOM, overflow flag at TOP.
// - Modes 8, 9: capture/compare A TOP, update and flag at BOTTOM.
// - Noise filter needs four equal samples before output changes.
// - Edge select zero captures falling edges, one captures rising edges.
// - Capture copies counter to capture register and sets capture flag.
// - Capture pin disabled when capture register serves as TOP.
// - Clock select zero stops; one to five divide by 1,8,64,256,1024.
// - Clock select six/seven counts falling/rising edges of external pin.
// - External pin edges count even when the pin drives as output.
// - Force bits cause a compare match in non-PWM modes only.
// - Forced match sets no flag and never clears the counter.
// - Force bits are strobes and read back as zero.
// - Counter accessed as two bytes through shared high-byte latch.
// - CPU counter write suppresses compare match on next timer tick.
// - Non-PWM output mode: 0 off, 1 toggle, 2 clear, 3 set.
// - Compare flag sets in timer cycle after counter equals compare.
`timescale 1ns/1ps
`include "timer16_defs.vh"

module timer16_core (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst_n,
    // CPU I/O port
    input  wire [7:0]  io_addr,
    input  wire [7:0]  io_wdata,
    input  wire        io_wr,
    input  wire        io_rd,
    output reg  [7:0]  io_rdata,
    // Pins
    input  wire        capture_input_pin,
    input  wire        ext_count_pin,
    output reg         compare_out_a,
    output reg         compare_out_b,
    output wire        compare_out_a_en,
    output wire        compare_out_b_en,
    // Status
    output reg         overflow_flag,
    output reg         capture_flag,
    output reg         compare_match_flag_a,
    output reg         compare_match_flag_b
);
    // Reset synchroniser
    reg        rst_s1_q;
    reg        rst_s2_q;
    wire       rst_i_n;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_i_n = rst_s2_q;

    // Pin synchronisers
    reg [1:0] cap_sync_q;
    reg [1:0] ext_sync_q;
    always @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            cap_sync_q <= 2'b00;
            ext_sync_q <= 2'b00;
        end else begin
            cap_sync_q <= {cap_sync_q[0], capture_input_pin};
            ext_sync_q <= {ext_sync_q[0], ext_count_pin};
        end
    end

    // Registers
    reg  [7:0]  ctrl_a_q;
    reg  [7:0]  ctrl_b_q;
    reg  [15:0] count_q;
    reg  [15:0] cmp_a_q;
    reg  [15:0] cmp_b_q;
    reg  [15:0] cmp_a_buf_q;
    reg  [15:0] cmp_b_buf_q;
    reg  [15:0] cap_q;
    reg  [7:0]  high_byte_latch_q;
    reg         dir_down_q;
    reg         block_match_q;
    reg         match_a_q;
    reg         match_b_q;

    wire [3:0] wave_gen_mode_sel;
    wire [1:0] mode_a;
    wire [1:0] mode_b;
    wire [2:0] clock_source_sel;
    assign wave_gen_mode_sel = {ctrl_b_q[`T16_B_WGM_HI:`T16_B_WGM_LO],
                                ctrl_a_q[`T16_A_WGM_HI:`T16_A_WGM_LO]};
    assign mode_a = ctrl_a_q[`T16_A_COMA_HI:`T16_A_COMA_LO];
    assign mode_b = ctrl_a_q[`T16_A_COMB_HI:`T16_A_COMB_LO];
    assign clock_source_sel = ctrl_b_q[`T16_B_CS_HI:`T16_B_CS_LO];

    // TOP value for the mode
    function [15:0] top_of;
        input [3:0]  m;
        input [15:0] ocra;
        input [15:0] icr;
        begin
            case (m)
                4'h0: top_of = `T16_TOP_MAX;
                4'h1, 4'h5: top_of = `T16_TOP_8BIT;
                4'h2, 4'h6: top_of = `T16_TOP_9BIT;
                4'h3, 4'h7: top_of = `T16_TOP_10BIT;
                4'h4, 4'h9, 4'hb, 4'hf: top_of = ocra;
                4'h8, 4'ha, 4'hc, 4'he: top_of = icr;
                default: top_of = `T16_TOP_MAX;
            endcase
        end
    endfunction

    // Compare update point for the mode
    function [1:0] upd_of;
        input [3:0] m;
        begin
            case (m)
                4'h0, 4'h4, 4'hc: upd_of = `T16_PT_IMM;
                4'h1, 4'h2, 4'h3, 4'ha, 4'hb: upd_of = `T16_PT_TOP;
                default: upd_of = `T16_PT_BOT;
            endcase
        end
    endfunction

    // Overflow flag point for the mode
    function [1:0] ovf_of;
        input [3:0] m;
        begin
            case (m)
                4'h0, 4'h4, 4'hc: ovf_of = `T16_PT_MAX;
                4'h5, 4'h6, 4'h7, 4'he, 4'hf: ovf_of = `T16_PT_TOP;
                default: ovf_of = `T16_PT_BOT;
            endcase
        end
    endfunction

    wire [15:0] top_val;
    wire [1:0]  upd_pt;
    wire [1:0]  ovf_pt;
    wire        is_pwm;
    wire        is_dual;
    wire        icr_top;
    wire        at_top;
    wire        at_bot;
    wire        tick;
    wire        cap_event;
    assign top_val = top_of(wave_gen_mode_sel, cmp_a_q, cap_q);
    assign upd_pt  = upd_of(wave_gen_mode_sel);
    assign ovf_pt  = ovf_of(wave_gen_mode_sel);
    assign is_pwm  = (upd_pt != `T16_PT_IMM);
    assign is_dual = (ovf_pt == `T16_PT_BOT);
    assign icr_top = (wave_gen_mode_sel == 4'h8) | (wave_gen_mode_sel == 4'ha) |
                     (wave_gen_mode_sel == 4'hc) | (wave_gen_mode_sel == 4'he);
    assign at_top  = (count_q == top_val);
    assign at_bot  = (count_q == `T16_BOTTOM);
    assign compare_out_a_en = (mode_a != 2'h0);
    assign compare_out_b_en = (mode_b != 2'h0);

    timer16_prescaler u_prescaler (
        .clk              (sys_clk),
        .rst_n            (rst_i_n),
        .clock_source_sel (clock_source_sel),
        .ext_count_sync   (ext_sync_q[1]),
        .tick_q           (tick)
    );

    timer16_capture_filter u_capture (
        .clk                     (sys_clk),
        .rst_n                   (rst_i_n),
        .capture_noise_filter_en (ctrl_b_q[`T16_B_NOISE]),
        .capture_edge_sel        (ctrl_b_q[`T16_B_EDGE]),
        .capture_enable          (~icr_top),
        .capture_sync            (cap_sync_q[1]),
        .capture_event_q         (cap_event)
    );

    // Output action on a (real or forced) match
    function out_act;
        input       cur;
        input [1:0] m;
        begin
            case (m)
                2'h1: out_act = ~cur;
                2'h2: out_act = 1'b0;
                2'h3: out_act = 1'b1;
                default: out_act = cur;
            endcase
        end
    endfunction

    wire wr_cnt_lo;
    wire wr_c;
    wire force_a;
    wire force_b;
    assign wr_cnt_lo = io_wr & (io_addr == `T16_OFS_CNT_LO);
    assign wr_c      = io_wr & (io_addr == `T16_OFS_CTRL_C);
    assign force_a   = wr_c & io_wdata[`T16_C_FORCE_A] & ~is_pwm;
    assign force_b   = wr_c & io_wdata[`T16_C_FORCE_B] & ~is_pwm;

    // Counter, compare, capture and CPU writes
    always @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            ctrl_a_q          <= `T16_CTRL_A_RST;
            ctrl_b_q          <= `T16_CTRL_B_RST;
            count_q           <= 16'h0000;
            cmp_a_q           <= 16'h0000;
            cmp_b_q           <= 16'h0000;
            cmp_a_buf_q       <= 16'h0000;
            cmp_b_buf_q       <= 16'h0000;
            cap_q             <= 16'h0000;
            high_byte_latch_q <= 8'h00;
            dir_down_q        <= 1'b0;
            block_match_q     <= 1'b0;
            match_a_q         <= 1'b0;
            match_b_q         <= 1'b0;
            overflow_flag     <= 1'b0;
            capture_flag      <= 1'b0;
            compare_match_flag_a <= 1'b0;
            compare_match_flag_b <= 1'b0;
            compare_out_a     <= 1'b0;
            compare_out_b     <= 1'b0;
        end else begin
            // Flags: hardware set wins over a write-one clear
            if (io_wr && io_addr == `T16_OFS_FLAGS) begin
                if (io_wdata[`T16_F_OVF])  overflow_flag <= 1'b0;
                if (io_wdata[`T16_F_CAP])  capture_flag  <= 1'b0;
                if (io_wdata[`T16_F_CMPA]) compare_match_flag_a <= 1'b0;
                if (io_wdata[`T16_F_CMPB]) compare_match_flag_b <= 1'b0;
            end
            if (tick) begin
                match_a_q <= (count_q == cmp_a_q) & ~block_match_q;
                match_b_q <= (count_q == cmp_b_q) & ~block_match_q;
                block_match_q <= 1'b0;
                if (match_a_q) compare_match_flag_a <= 1'b1;
                if (match_b_q) compare_match_flag_b <= 1'b1;
                if (match_a_q && !is_pwm) compare_out_a <= out_act(compare_out_a, mode_a);
                if (match_b_q && !is_pwm) compare_out_b <= out_act(compare_out_b, mode_b);
                // Count sequence
                if (is_dual) begin
                    if (!dir_down_q && at_top) begin
                        dir_down_q <= 1'b1;
                        count_q    <= count_q - 16'h0001;
                    end else if (dir_down_q && at_bot) begin
                        dir_down_q <= 1'b0;
                        count_q    <= count_q + 16'h0001;
                    end else begin
                        count_q <= dir_down_q ? count_q - 16'h0001 : count_q + 16'h0001;
                    end
                end else if (at_top && wave_gen_mode_sel != 4'h0) begin
                    count_q <= `T16_BOTTOM;
                end else begin
                    count_q <= count_q + 16'h0001;
                end
                // Overflow flag point
                if ((ovf_pt == `T16_PT_MAX && count_q == `T16_TOP_MAX) ||
                    (ovf_pt == `T16_PT_TOP && at_top) ||
                    (ovf_pt == `T16_PT_BOT && at_bot && dir_down_q)) begin
                    overflow_flag <= 1'b1;
                end
                // Double-buffered compare update
                if ((upd_pt == `T16_PT_TOP && at_top) ||
                    (upd_pt == `T16_PT_BOT && at_bot)) begin
                    cmp_a_q <= cmp_a_buf_q;
                    cmp_b_q <= cmp_b_buf_q;
                end
            end
            if (upd_pt == `T16_PT_IMM) begin
                cmp_a_q <= cmp_a_buf_q;
                cmp_b_q <= cmp_b_buf_q;
            end
            // Forced strobes change the output only, no flag, no clear
            if (force_a) compare_out_a <= out_act(compare_out_a, mode_a);
            if (force_b) compare_out_b <= out_act(compare_out_b, mode_b);
            // Input capture
            if (cap_event) begin
                cap_q        <= count_q;
                capture_flag <= 1'b1;
            end
            // CPU writes
            if (io_wr) begin
                case (io_addr)
                    `T16_OFS_CTRL_A: ctrl_a_q <= io_wdata & `T16_CTRL_A_MASK;
                    `T16_OFS_CTRL_B: ctrl_b_q <= io_wdata & `T16_CTRL_B_MASK;
                    `T16_OFS_CNT_HI, `T16_OFS_CMPA_HI, `T16_OFS_CMPB_HI,
                    `T16_OFS_CAP_HI: high_byte_latch_q <= io_wdata;
                    `T16_OFS_CNT_LO: begin
                        count_q       <= {high_byte_latch_q, io_wdata};
                        block_match_q <= 1'b1;
                    end
                    `T16_OFS_CMPA_LO: cmp_a_buf_q <= {high_byte_latch_q, io_wdata};
                    `T16_OFS_CMPB_LO: cmp_b_buf_q <= {high_byte_latch_q, io_wdata};
                    `T16_OFS_CAP_LO: if (icr_top) cap_q <= {high_byte_latch_q, io_wdata};
                    default: ;
                endcase
            end
            // Counter or capture low-byte read latches the high byte atomically
            if (io_rd && !io_wr) begin
                if (io_addr == `T16_OFS_CNT_LO) high_byte_latch_q <= count_q[15:8];
                if (io_addr == `T16_OFS_CAP_LO) high_byte_latch_q <= cap_q[15:8];
            end
        end
    end

    // Read data mux
    always @* begin
        case (io_addr)
            `T16_OFS_CTRL_A:  io_rdata = ctrl_a_q;
            `T16_OFS_CTRL_B:  io_rdata = ctrl_b_q;
            `T16_OFS_CTRL_C:  io_rdata = 8'h00;
            `T16_OFS_CNT_LO:  io_rdata = count_q[7:0];
            `T16_OFS_CNT_HI:  io_rdata = high_byte_latch_q;
            `T16_OFS_CAP_LO:  io_rdata = cap_q[7:0];
            `T16_OFS_CAP_HI:  io_rdata = high_byte_latch_q;
            `T16_OFS_CMPA_LO: io_rdata = cmp_a_q[7:0];
            `T16_OFS_CMPA_HI: io_rdata = cmp_a_q[15:8];
            `T16_OFS_CMPB_LO: io_rdata = cmp_b_q[7:0];
            `T16_OFS_CMPB_HI: io_rdata = cmp_b_q[15:8];
            `T16_OFS_FLAGS:   io_rdata = {2'b00, capture_flag, 2'b00,
                                          compare_match_flag_b, compare_match_flag_a,
                                          overflow_flag};
            default:          io_rdata = 8'h00;
        endcase
    end
endmodule // timer16_core

/* File: testbench/timer16_monitor.sv */
// Port checker for the timer core
`timescale 1ns/1ps
module timer16_monitor (
    // Clock, reset and bus
    input wire       sys_clk,
    input wire       rst_n,
    input wire [7:0] io_addr,
    input wire [7:0] io_wdata,
    input wire       io_wr,
    input wire [7:0] io_rdata,
    // Outputs and flags
    input wire       compare_out_a,
    input wire       compare_out_a_en,
    input wire       compare_out_b_en,
    input wire       overflow_flag,
    input wire       capture_flag,
    input wire       compare_match_flag_a,
    input wire       compare_match_flag_b
);
    reg  [7:0] ca_q;
    reg  [7:0] cb_q;
    wire [3:0] mode = {cb_q[4:3], ca_q[1:0]};
    wire       stop = cb_q[2:0] == 3'h0;
    wire       npwm = mode == 4'h0 || mode == 4'h4 || mode == 4'hc;
    wire       frc = io_wr && io_addr == 8'h82 && io_wdata[7] && stop;
    // Shadow copies of control A and B
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ca_q <= 8'h00;
            cb_q <= 8'h00;
        end else if (io_wr && io_addr == 8'h80) begin
            ca_q <= io_wdata & 8'hf3;
        end else if (io_wr && io_addr == 8'h81) begin
            cb_q <= io_wdata & 8'hdf;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_frc_tgl; frc && npwm && ca_q[7:6] == 2'h1; endsequence
    sequence s_frc_pwm; frc && !npwm; endsequence
    property p_c_zero; io_addr == 8'h82 |-> io_rdata == 8'h00; endproperty
    a_c_zero: assert property (p_c_zero) else $error("control C read not zero");
    property p_a_read; io_addr == 8'h80 |-> io_rdata == ca_q; endproperty
    a_a_read: assert property (p_a_read) else $error("control A readback");
    property p_b_read; io_addr == 8'h81 |-> io_rdata == cb_q; endproperty
    a_b_read: assert property (p_b_read) else $error("control B readback");
    property p_out_en;
        compare_out_a_en == (ca_q[7:6] != 2'h0) && compare_out_b_en == (ca_q[5:4] != 2'h0);
    endproperty
    a_out_en: assert property (p_out_en) else $error("output enable wrong");
    property p_stopped;
        stop[*4] |-> !$rose(overflow_flag) && !$rose(compare_match_flag_a);
    endproperty
    a_stopped: assert property (p_stopped) else $error("flag set while stopped");
    property p_tgl; s_frc_tgl |-> ##[1:3] $changed(compare_out_a); endproperty
    a_tgl: assert property (p_tgl) else $error("forced toggle missing");
    property p_pwm; s_frc_pwm |=> $stable(compare_out_a)[*3]; endproperty
    a_pwm: assert property (p_pwm) else $error("force acted in PWM mode");
    property p_noflag;
        frc |=> (!$rose(compare_match_flag_a) && !$rose(compare_match_flag_b))[*3];
    endproperty
    a_noflag: assert property (p_noflag) else $error("force set a flag");
    property p_cap_top; (mode == 4'hc && stop)[*8] |-> !$rose(capture_flag); endproperty
    a_cap_top: assert property (p_cap_top) else $error("capture while TOP");
endmodule // timer16_monitor
bind timer16_core timer16_monitor mon (.sys_clk, .rst_n, .io_addr, .io_wdata, .io_wr,
    .io_rdata, .compare_out_a, .compare_out_a_en, .compare_out_b_en, .overflow_flag,
    .capture_flag, .compare_match_flag_a, .compare_match_flag_b);

/* File: testbench/tb.sv */
// Self-checking bench for the timer core
`timescale 1ns/1ps
module tb;
    reg         sys_clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [7:0]  io_addr = 8'h00;
    reg  [7:0]  io_wdata = 8'h00;
    reg         io_wr = 1'b0;
    reg         io_rd = 1'b0;
    reg         cap_pin = 1'b0;
    reg         ext_pin = 1'b0;
    wire [7:0]  io_rdata;
    wire        out_a;
    wire        ovf;
    wire        cap_f;
    wire        fa;
    wire        out_b;
    integer     failures = 0;
    integer     checks_done = 0;
    integer     i;
    integer     d;
    reg  [15:0] v;
    reg  [15:0] w;
    // Design under test
    timer16_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
        .capture_input_pin(cap_pin), .ext_count_pin(ext_pin), .compare_out_a(out_a),
        .compare_out_b(out_b), .compare_out_a_en(), .compare_out_b_en(),
        .overflow_flag(ovf), .capture_flag(cap_f), .compare_match_flag_a(fa),
        .compare_match_flag_b());
    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    task chk(input [15:0] seen, input [15:0] exp, input [79:0] what);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("wrong value %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge sys_clk);
    endtask
    task wr(input [7:0] a, input [7:0] dt);
        begin
            io_addr = a;
            io_wdata = dt;
            io_wr = 1'b1;
            cyc(1);
            io_wr = 1'b0;
            cyc(1);
        end
    endtask
    task wr16(input [7:0] a, input [15:0] dt);
        begin
            wr(a + 8'h01, dt[15:8]);
            wr(a, dt[7:0]);
        end
    endtask
    task rd16(input [7:0] a, output [15:0] r);
        begin
            io_addr = a;
            io_rd = 1'b1;
            #1 r[7:0] = io_rdata;
            cyc(1);
            io_addr = a + 8'h01;
            #1 r[15:8] = io_rdata;
            cyc(1);
            io_rd = 1'b0;
            cyc(1);
        end
    endtask
    task rchk(input [7:0] a, input [7:0] e);
        begin
            io_addr = a;
            #1 chk(io_rdata, e, "reg");
            cyc(1);
        end
    endtask
    // Overflow point for one mode, counter run briefly from a start value
    task t_ovf(input [7:0] ma, input [7:0] mb, input [15:0] st, input e);
        begin
            wr(8'h80, ma);
            wr(8'h81, mb);
            wr(8'h36, 8'hff);
            wr16(8'h84, st);
            wr(8'h81, mb | 8'h01);
            cyc(12);
            wr(8'h81, mb);
            chk(ovf, e, "ovf");
        end
    endtask
    // Internal prescaler taps, then a stopped counter
    task t_clk;
        begin
            wr(8'h80, 8'h00);
            for (i = 1; i < 6; i = i + 1) begin
                d = i == 1 ? 1 : i == 2 ? 8 : i == 3 ? 64 : i == 4 ? 256 : 1024;
                wr16(8'h84, 16'h0000);
                wr(8'h81, i[7:0]);
                cyc(4 * d);
                wr(8'h81, 8'h00);
                rd16(8'h84, v);
                chk(v >= 3 && v <= 12, 1'b1, "count");
            end
            cyc(40);
            rd16(8'h84, w);
            chk(w, v, "stopped");
        end
    endtask
    // External pin: five rising and four falling edges
    task t_ext;
        for (i = 6; i < 8; i = i + 1) begin
            wr16(8'h84, 16'h0000);
            wr(8'h81, i[7:0]);
            repeat (4) begin
                ext_pin = 1'b1;
                cyc(4);
                ext_pin = 1'b0;
                cyc(4);
            end
            ext_pin = 1'b1;
            cyc(8);
            wr(8'h81, 8'h00);
            rd16(8'h84, v);
            chk(v, i - 2, "ext");
            ext_pin = 1'b0;
            cyc(8);
        end
    endtask
    // Edge select, copy, filter and capture-as-TOP
    task t_cap;
        begin
            wr16(8'h84, 16'h1234);
            wr(8'h36, 8'hff);
            cap_pin = 1'b1;
            cyc(12);
            chk(cap_f, 1'b0, "rise");
            cap_pin = 1'b0;
            cyc(12);
            chk(cap_f, 1'b1, "fall");
            rd16(8'h86, v);
            chk(v, 16'h1234, "capval");
            wr(8'h36, 8'h20);
            wr(8'h81, 8'hc0);
            cap_pin = 1'b1;
            cyc(3);
            cap_pin = 1'b0;
            cyc(12);
            chk(cap_f, 1'b0, "glitch");
            cap_pin = 1'b1;
            cyc(12);
            chk(cap_f, 1'b1, "filtered");
            wr(8'h36, 8'h20);
            cap_pin = 1'b0;
            wr(8'h81, 8'hd8);
            cyc(12);
            cap_pin = 1'b1;
            cyc(12);
            chk(cap_f, 1'b0, "captop");
            wr(8'h81, 8'h00);
        end
    endtask
    // Forced matches: set, clear, toggle, PWM and CLEAR_ON_MATCH_MODE cases
    task t_force;
        begin
            wr(8'h36, 8'hff);
            for (i = 3; i > 0; i = i - 1) begin
                wr(8'h80, {i[1:0], i[1:0], 4'h0});
                wr(8'h82, 8'hc0);
                cyc(3);
                chk(out_a, i != 2, "force");
                chk(out_b, i != 2, "forceb");
            end
            chk(fa, 1'b0, "noflag");
            rchk(8'h82, 8'h00);
            wr(8'h80, 8'h41);
            wr(8'h81, 8'h08);
            wr(8'h82, 8'h80);
            cyc(3);
            chk(out_a, 1'b1, "pwm");
            wr(8'h80, 8'h40);
            wr16(8'h84, 16'h0055);
            wr(8'h82, 8'h80);
            rd16(8'h84, v);
            chk(v, 16'h0055, "noclear");
        end
    endtask
    // Counter write blocks the next match, a later match sets the flag
    task t_supp;
        begin
            wr(8'h80, 8'h00);
            wr(8'h81, 8'h00);
            wr16(8'h88, 16'h0010);
            for (i = 0; i < 2; i = i + 1) begin
                wr(8'h36, 8'hff);
                wr16(8'h84, 16'h0010 - i[15:0]);
                wr(8'h81, 8'h01);
                cyc(6);
                wr(8'h81, 8'h00);
                chk(fa, i, "match");
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        cyc(12);
        rst_n = 1'b1;
        cyc(4);
        rchk(8'h81, 8'h00);
        wr(8'h80, 8'hff);
        wr(8'h81, 8'hd8);
        rchk(8'h80, 8'hf3);
        rchk(8'h81, 8'hd8);
        t_ovf(8'h00, 8'h00, 16'hfffd, 1'b1);
        t_ovf(8'h01, 8'h08, 16'h00fd, 1'b1);
        t_ovf(8'h01, 8'h00, 16'h00fd, 1'b0);
        t_ovf(8'h01, 8'h10, 16'h0003, 1'b1);
        t_clk;
        t_ext;
        t_cap;
        t_force;
        t_supp;
        summarize;
    end
endmodule // tb
